// file: uhrs_map.svh
// uhrs_map.svh: timing counts and strap codes of the hub reset sequencer
// assumes a 50 MHz system clock (20 ns period)
`ifndef UHRS_MAP_SVH
`define UHRS_MAP_SVH

`define UHRS_CLK_PERIOD_NS   20
`define UHRS_RST_MIN_NS      1000
`define UHRS_RST_MIN_CYC     ((`UHRS_RST_MIN_NS + `UHRS_CLK_PERIOD_NS - 1) / `UHRS_CLK_PERIOD_NS)
`define UHRS_OPER_US         500
`define UHRS_OPER_CYC        ((`UHRS_OPER_US * 1000) / `UHRS_CLK_PERIOD_NS)
`define UHRS_ATTACH_MS       100
`define UHRS_ATTACH_CYC      ((`UHRS_ATTACH_MS * 1000000) / `UHRS_CLK_PERIOD_NS)
`define UHRS_REQ_MS          5
`define UHRS_REQ_CYC         ((`UHRS_REQ_MS * 1000000) / `UHRS_CLK_PERIOD_NS)
`define UHRS_TT_BUFS         4
`define UHRS_STRAP_NONE      2'h0
`define UHRS_STRAP_P1        2'h1
`define UHRS_ADDR_DEFAULT    7'h00

`endif

// file: uhrs_pkg.sv
// uhrs_pkg.sv: types of the hub reset and default-configuration sequencer
// assumes uhrs_map.svh is on the include path
package uhrs_pkg;
  typedef enum logic [3:0] {
    UHRS_ST_RESET   = 4'h1,
    UHRS_ST_WAKE    = 4'h2,
    UHRS_ST_ATTACH  = 4'h4,
    UHRS_ST_ACTIVE  = 4'h8
  } uhrs_state_t;

  typedef struct packed {
    uhrs_state_t state;
    logic [31:0] timer;
    logic [31:0] reqTimer;
    logic [1:0]  fixedPorts;
    logic [6:0]  devAddr;
    logic        configured;
    logic        suspended;
    logic [1:0]  portPowerEnable;
    logic [1:0]  portEnable;
    logic        phyEnable;
    logic        oscEnable;
    logic        attach;
    logic        operational;
    logic        abort;
    logic [3:0]  ttValid;
    logic        reqTimeout;
  } uhrs_regs_t;
endpackage

// file: uhrs_reset_seq.sv
// uhrs_reset_seq.sv: reset and default-configuration sequencer of a two-port hub
// assumes the hub core, phys and power switches sit outside and obey these levels
//
// Notes on behaviour
// - during hardware reset all ports disabled and port power enables off
// - during hardware reset transceivers are off and pairs float
// - hardware reset aborts all transactions at once, no state kept
// - hardware reset returns every register to its default, mostly zero
// - during hardware reset the oscillator and pll are stopped
// - hub is operational 500 us after the reset is released
// - outputs go inactive within 2 us of reset assertion
// - attach is signalled upstream within 100 ms of leaving reset
// - each host request completes within 5 ms once enumeration starts
// - upstream bus reset sets the device address to zero
// - upstream bus reset returns the hub to unconfigured
// - upstream bus reset drops power enable of both downstream ports
// - upstream bus reset empties all translator buffers
// - a bus reset while suspended moves the hub to active
// - upstream reset is never forwarded to downstream ports
// - one translator shared by both ports, with four non-periodic buffers
// - fixed internal defaults, only the fixed-port strap overrides anything
// - defaults: straps on, self-powered, per-port switching and sensing
// - both strap inputs sampled together at reset release
// - strap 00 none fixed, 01 port 1 fixed, 10/11 both fixed
`include "uhrs_map.svh"

module uhrs_reset_seq (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [1:0] fixed_port_strap,
  input  wire logic       busReset,
  input  wire logic       suspendReq,
  input  wire logic       resumeReq,
  input  wire logic       setAddrValid,
  input  wire logic [6:0] setAddrValue,
  input  wire logic       setConfigValid,
  input  wire logic       setConfigValue,
  input  wire logic [1:0] portPowerReq,
  input  wire logic [1:0] portEnableReq,
  input  wire logic       ttAlloc,
  input  wire logic [1:0] ttAllocIdx,
  input  wire logic       ttFree,
  input  wire logic [1:0] ttFreeIdx,
  input  wire logic       reqStart,
  input  wire logic       reqDone,
  output logic [1:0]      port_power_enable,
  output logic [1:0]      portEnable,
  output logic [1:0]      fixedPorts,
  output logic            phyEnable,
  output logic            oscEnable,
  output logic            attach,
  output logic            operational,
  output logic            abortAll,
  output logic [6:0]      devAddr,
  output logic            configured,
  output logic            suspended,
  output logic [3:0]      ttValid,
  output logic            reqTimeout,
  output logic            downstreamReset,
  output logic            selfPowered,
  output logic            perPortSwitching,
  output logic            perPortOcSense,
  output logic            strapEnabled
);
  import uhrs_pkg::*;

  uhrs_regs_t r_q;
  uhrs_regs_t r_d;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [1:0] decodeStrap(input logic [1:0] s);
    case (s)
      `UHRS_STRAP_NONE: decodeStrap = 2'h0;
      `UHRS_STRAP_P1:   decodeStrap = 2'h1;
      default:          decodeStrap = 2'h3;
    endcase
  endfunction

  function automatic logic [3:0] oneHot(input logic [1:0] i);
    oneHot = 4'h1 << i;
  endfunction

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.abort = 1'b0;
    case (r_q.state)
      UHRS_ST_RESET: begin
        // first clocked cycle after release: catch the strap pair together
        r_d.fixedPorts = decodeStrap(fixed_port_strap);
        r_d.oscEnable = 1'b1;
        r_d.timer = 32'h0;
        r_d.state = UHRS_ST_WAKE;
      end
      UHRS_ST_WAKE: begin
        // hub held inactive until the restarted clock has counted out
        if (r_q.timer >= 32'(`UHRS_OPER_CYC - 2)) begin
          r_d.operational = 1'b1;
          r_d.phyEnable = 1'b1;
          r_d.timer = 32'h0;
          r_d.state = UHRS_ST_ATTACH;
        end else begin
          r_d.timer = r_q.timer + 32'h1;
        end
      end
      UHRS_ST_ATTACH: begin
        // attach at once; well inside the allowed window
        r_d.attach = 1'b1;
        r_d.state = UHRS_ST_ACTIVE;
      end
      UHRS_ST_ACTIVE: begin
        if (setAddrValid) begin
          r_d.devAddr = setAddrValue;
        end
        if (setConfigValid) begin
          r_d.configured = setConfigValue;
        end
        if (suspendReq) begin
          r_d.suspended = 1'b1;
        end
        if (resumeReq) begin
          r_d.suspended = 1'b0;
        end
        if (r_q.configured) begin
          r_d.portPowerEnable = portPowerReq;
          r_d.portEnable = portEnableReq & portPowerReq;
        end
        // one shared translator, four buffers; alloc beats free on one index
        if (ttFree) begin
          r_d.ttValid = r_d.ttValid & ~oneHot(ttFreeIdx);
        end
        if (ttAlloc) begin
          r_d.ttValid = r_d.ttValid | oneHot(ttAllocIdx);
        end
        // request watchdog: flags a request that overruns its budget
        if (reqDone) begin
          r_d.reqTimer = 32'h0;
        end else if (reqStart || r_q.reqTimer != 32'h0) begin
          if (r_q.reqTimer >= 32'(`UHRS_REQ_CYC)) begin
            r_d.reqTimeout = 1'b1;
            r_d.abort = 1'b1;
            r_d.reqTimer = 32'h0;
          end else begin
            r_d.reqTimer = r_q.reqTimer + 32'h1;
          end
        end
        if (busReset) begin
          r_d.devAddr = `UHRS_ADDR_DEFAULT;
          r_d.configured = 1'b0;
          r_d.portPowerEnable = 2'h0;
          r_d.portEnable = 2'h0;
          r_d.ttValid = 4'h0;
          r_d.suspended = 1'b0;
          r_d.reqTimer = 32'h0;
          r_d.abort = 1'b1;
        end
      end
      default: begin
        r_d.state = UHRS_ST_RESET;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      // outputs inactive and abortAll raised on the first edge, far inside the 2 us limit
      r_q <= '0;
      r_q.state <= UHRS_ST_RESET;
      r_q.abort <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs, straight from flip-flops except the tied-off constants
  // --------------------------------------------------------------------------
  assign port_power_enable = r_q.portPowerEnable;
  assign portEnable = r_q.portEnable;
  assign fixedPorts = r_q.fixedPorts;
  assign phyEnable = r_q.phyEnable;
  assign oscEnable = r_q.oscEnable;
  assign attach = r_q.attach;
  assign operational = r_q.operational;
  assign abortAll = r_q.abort;
  assign devAddr = r_q.devAddr;
  assign configured = r_q.configured;
  assign suspended = r_q.suspended;
  assign ttValid = r_q.ttValid;
  assign reqTimeout = r_q.reqTimeout;
  // upstream reset never reaches the downstream ports
  assign downstreamReset = 1'b0;
  // fixed defaults with no override path
  assign selfPowered = 1'b1;
  assign perPortSwitching = 1'b1;
  assign perPortOcSense = 1'b1;
  assign strapEnabled = 1'b1;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence sReleased;
    $rose(nrst);
  endsequence

  sequence sWaitOper;
    !operational [*8];
  endsequence

  sequence sOperRise;
    $rose(operational);
  endsequence

  sequence sAttachRise;
    $rose(attach);
  endsequence

  sequence sBusResetTaken;
    busReset && r_q.state == UHRS_ST_ACTIVE;
  endsequence

  sequence sQuietAfterReset;
    !busReset && !setConfigValid;
  endsequence

  // --------------------------------------------------------------------------
  // check helpers
  // --------------------------------------------------------------------------
  // cycles since release, counted apart from the sequencer timer so that a
  // slip in the wake count cannot hide itself; saturates instead of wrapping
  logic [31:0] relCnt_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      relCnt_q <= 32'h0;
    end else if (relCnt_q != 32'hffffffff) begin
      relCnt_q <= relCnt_q + 32'h1;
    end
  end

  chk_reset_power_off: assert property (@(posedge clk_sys)
    !nrst |=> port_power_enable == 2'h0 && portEnable == 2'h0)
    else $error("port power on during reset");
  chk_reset_phy_off: assert property (@(posedge clk_sys)
    !nrst |=> !phyEnable && !attach)
    else $error("phy active during reset");
  chk_reset_abort: assert property (@(posedge clk_sys)
    !nrst |=> abortAll && ttValid == 4'h0)
    else $error("transactions not aborted by reset");
  chk_reset_defaults: assert property (@(posedge clk_sys)
    !nrst |=> devAddr == 7'h00 && !configured && !suspended)
    else $error("register not at default after reset");
  chk_reset_osc_off: assert property (@(posedge clk_sys)
    !nrst |=> !oscEnable)
    else $error("oscillator running during reset");
  chk_oper_delay: assert property (@(posedge clk_sys) disable iff (!nrst)
    sReleased |-> sWaitOper)
    else $error("hub operational too early");
  chk_strap_map: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(r_q.state) == UHRS_ST_RESET && $past(nrst) |->
    fixedPorts == decodeStrap($past(fixed_port_strap)))
    else $error("strap decode wrong");
  chk_bus_rst_addr: assert property (@(posedge clk_sys) disable iff (!nrst)
    busReset && r_q.state == UHRS_ST_ACTIVE |=> devAddr == 7'h00 && !configured)
    else $error("bus reset left address or configuration");
  chk_bus_rst_power: assert property (@(posedge clk_sys) disable iff (!nrst)
    busReset && r_q.state == UHRS_ST_ACTIVE |=> port_power_enable == 2'h0 && ttValid == 4'h0)
    else $error("bus reset left port power or tt buffers");
  chk_bus_rst_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
    busReset && suspended |=> !suspended)
    else $error("bus reset did not resume");

  chk_oper_exact: assert property (@(posedge clk_sys) disable iff (!nrst)
    sOperRise |-> relCnt_q == 32'(`UHRS_OPER_CYC) && phyEnable && oscEnable)
    else $error("hub not operational at the end of the wake delay");
  chk_attach_time: assert property (@(posedge clk_sys) disable iff (!nrst)
    sAttachRise |-> operational && relCnt_q <= 32'(`UHRS_ATTACH_CYC))
    else $error("attach late or ahead of the operational point");
  chk_held_inactive: assert property (@(posedge clk_sys)
    !operational |-> !attach && !phyEnable && port_power_enable == 2'h0)
    else $error("hub active before the wake delay ran out");
  chk_strap_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    r_q.state != UHRS_ST_RESET |=> $stable(fixedPorts))
    else $error("strap resampled outside reset release");
  chk_tt_alloc: assert property (@(posedge clk_sys) disable iff (!nrst)
    r_q.state == UHRS_ST_ACTIVE && ttAlloc && !busReset |=> ttValid[$past(ttAllocIdx)])
    else $error("allocated translator buffer not marked");
  chk_tt_free: assert property (@(posedge clk_sys) disable iff (!nrst)
    r_q.state == UHRS_ST_ACTIVE && ttFree && !(ttAlloc && ttAllocIdx == ttFreeIdx) |=>
    !ttValid[$past(ttFreeIdx)])
    else $error("freed translator buffer still marked");
  chk_bus_rst_settle: assert property (@(posedge clk_sys) disable iff (!nrst)
    sBusResetTaken ##1 sQuietAfterReset |=>
    !abortAll && !configured && port_power_enable == 2'h0)
    else $error("bus reset state not held once the host went quiet");
endmodule // uhrs_reset_seq

// file: uhrs_host_model.sv
// uhrs_host_model.sv: upstream host model issuing one-cycle request pulses
// assumes the bench calls its tasks and the hub takes pulses on rising clk_sys
module uhrs_host_model #(
  parameter int HOLD_CYC = 5000000  // 100 ms at 50 MHz, shortened by the bench
) (
  input  wire logic  clk_sys,
  output logic       busReset,
  output logic       suspendReq,
  output logic       resumeReq,
  output logic       setAddrValid,
  output logic [6:0] setAddrValue,
  output logic       setConfigValid,
  output logic       setConfigValue,
  output logic       ttAlloc,
  output logic [1:0] ttAllocIdx,
  output logic       ttFree,
  output logic [1:0] ttFreeIdx,
  output logic       reqStart,
  output logic       reqDone
);
  initial begin
    {busReset, suspendReq, resumeReq, setAddrValid, setConfigValid} = 5'h00;
    {setConfigValue, ttAlloc, ttFree, reqStart, reqDone} = 5'h00;
    {setAddrValue, ttAllocIdx, ttFreeIdx} = 11'h000;
  end

  // one pulse per call; data lines turn over once the pulse is gone
  task automatic cmd(input int k, input logic [6:0] v);
    @(posedge clk_sys);
    case (k)
      0: busReset <= 1'b1;
      1: begin setAddrValid <= 1'b1; setAddrValue <= v; end
      2: begin setConfigValid <= 1'b1; setConfigValue <= v[0]; end
      3: suspendReq <= 1'b1;
      4: begin ttAlloc <= 1'b1; ttAllocIdx <= v[1:0]; end
      5: reqStart <= 1'b1;
      6: reqDone <= 1'b1;
      8: begin ttFree <= 1'b1; ttFreeIdx <= v[1:0]; end
      default: resumeReq <= 1'b1;
    endcase
    @(posedge clk_sys);
    {busReset, suspendReq, resumeReq, setAddrValid, setConfigValid} <= 5'h00;
    {ttAlloc, ttFree, reqStart, reqDone} <= 4'h0;
    setAddrValue <= ~setAddrValue;
    setConfigValue <= ~setConfigValue;
    ttAllocIdx <= ~ttAllocIdx;
    ttFreeIdx <= ~ttFreeIdx;
  endtask

  task automatic enum_start;
    repeat (HOLD_CYC) @(posedge clk_sys);
    cmd(0, 7'h00);
  endtask

  // lat sets how slowly the host closes a request
  task automatic request(input int lat);
    cmd(5, 7'h00);
    repeat (lat) @(posedge clk_sys);
    cmd(6, 7'h00);
  endtask
endmodule // uhrs_host_model

// file: tb_top.sv
// tb_top.sv: self-checking bench of the hub reset and default-configuration sequencer
// assumes uhrs_pkg, uhrs_reset_seq and uhrs_host_model are compiled before it
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, nrst;
  logic [1:0]  fixed_port_strap, portPowerReq, portEnableReq, code, sb, fpExp;
  logic [1:0]  port_power_enable, portEnable, fixedPorts, ttAllocIdx, ttFreeIdx;
  logic        busReset, suspendReq, resumeReq, setAddrValid, setConfigValid, setConfigValue;
  logic        ttAlloc, ttFree, reqStart, reqDone, phyEnable, oscEnable, attach, operational;
  logic        abortAll, configured, suspended, reqTimeout, downstreamReset, selfPowered;
  logic        perPortSwitching, perPortOcSense, strapEnabled;
  logic [6:0]  setAddrValue, devAddr, addr;
  logic [3:0]  ttValid, upExp;
  logic [29:0] expQ[$], mskQ[$];
  int          bad_count, comparisons, i;
  wire  [29:0] obsVec = {port_power_enable, portEnable, fixedPorts, phyEnable, oscEnable,
    attach, operational, abortAll, devAddr, configured, suspended, ttValid, reqTimeout,
    downstreamReset, selfPowered, perPortSwitching, perPortOcSense, strapEnabled};

  uhrs_reset_seq u_dut (.clk_sys, .nrst, .fixed_port_strap, .busReset, .suspendReq,
    .resumeReq, .setAddrValid, .setAddrValue, .setConfigValid, .setConfigValue,
    .portPowerReq, .portEnableReq, .ttAlloc, .ttAllocIdx, .ttFree, .ttFreeIdx, .reqStart,
    .reqDone, .port_power_enable, .portEnable, .fixedPorts, .phyEnable, .oscEnable, .attach,
    .operational, .abortAll, .devAddr, .configured, .suspended, .ttValid, .reqTimeout,
    .downstreamReset, .selfPowered, .perPortSwitching, .perPortOcSense, .strapEnabled);
  uhrs_host_model #(.HOLD_CYC(200)) u_host (.clk_sys, .busReset, .suspendReq, .resumeReq,
    .setAddrValid, .setAddrValue, .setConfigValid, .setConfigValue, .ttAlloc, .ttAllocIdx,
    .ttFree, .ttFreeIdx, .reqStart, .reqDone);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // pm low leaves the port-enable field out where its value is left open
  task automatic note(input logic [1:0] pp, pe, input logic ab, input logic [6:0] ad,
                      input logic cf, su, input logic [3:0] tt, input logic pm);
    expQ.push_back({pp, pe, fpExp, upExp, ab, ad, cf, su, tt, 1'b0, 5'h0f});
    mskQ.push_back({2'h3, {2{pm}}, 26'h3ffffff});
  endtask
  task automatic check(input logic [29:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(negedge clk_sys) begin
    while (expQ.size() > 0) begin
      check(obsVec & mskQ[0], expQ[0] & mskQ[0]);
      expQ.delete(0);
      mskQ.delete(0);
    end
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end

  // ----------------------------------------
  // stimulus: strap codes, power-up, enumeration
  // ----------------------------------------
  initial begin
    {nrst, fixed_port_strap, portPowerReq, portEnableReq} = 7'h00;
    {fpExp, upExp} = 6'h00;
    void'($urandom(25347));
    sb = 2'($urandom);
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      nrst <= 1'b0;
      @(posedge clk_sys);
      {fpExp, upExp} = 6'h00;
      note(2'h0, 2'h0, 1'b1, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
      repeat (49) @(posedge clk_sys);
      code = 2'(i) ^ sb;
      fixed_port_strap <= code;
      nrst <= 1'b1;
      @(posedge clk_sys);
      fpExp = (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h3;
      upExp = 4'h4;
      note(2'h0, 2'h0, 1'b0, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
      fixed_port_strap <= ~code;
    end
    repeat (24998) @(posedge clk_sys);
    note(2'h0, 2'h0, 1'b0, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
    @(posedge clk_sys);
    upExp = 4'hd;
    note(2'h0, 2'h0, 1'b0, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
    @(posedge clk_sys);
    upExp = 4'hf;
    note(2'h0, 2'h0, 1'b0, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
    portPowerReq <= 2'h3;
    portEnableReq <= 2'h3;
    u_host.enum_start();
    note(2'h0, 2'h0, 1'b1, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
    addr = 7'($urandom_range(127, 1));
    u_host.cmd(1, addr);
    u_host.cmd(2, 7'h01);
    @(posedge clk_sys);
    note(2'h3, 2'h3, 1'b0, addr, 1'b1, 1'b0, 4'h0, 1'b1);
    for (i = 0; i < 4; i++) u_host.cmd(4, 7'(i));
    note(2'h3, 2'h3, 1'b0, addr, 1'b1, 1'b0, 4'hf, 1'b1);
    u_host.cmd(8, 7'h02);
    u_host.request(0);
    u_host.request(40);
    note(2'h3, 2'h3, 1'b0, addr, 1'b1, 1'b0, 4'hb, 1'b1);
    u_host.cmd(3, 7'h00);
    note(2'h3, 2'h3, 1'b0, addr, 1'b1, 1'b1, 4'hb, 1'b1);
    u_host.cmd(7, 7'h00);
    note(2'h3, 2'h3, 1'b0, addr, 1'b1, 1'b0, 4'hb, 1'b1);
    u_host.cmd(3, 7'h00);
    u_host.cmd(0, 7'h00);
    note(2'h0, 2'h0, 1'b1, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
    @(posedge clk_sys);
    note(2'h0, 2'h0, 1'b0, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
    nrst <= 1'b0;
    @(posedge clk_sys);
    {fpExp, upExp} = 6'h00;
    note(2'h0, 2'h0, 1'b1, 7'h00, 1'b0, 1'b0, 4'h0, 1'b1);
    @(negedge clk_sys);
    #1;
    give_verdict();
  end
endmodule // tb_top
